// ---- logic/ssm_pkg.sv ----
// constants, types and register map for the stage mask control block
package ssm_pkg;
   localparam int FRAME_BITS = 24;
   localparam int ADDR_BITS = 15;
   localparam int DATA_BITS = 8;
   localparam logic [4:0] CNT_INSTR_DONE = 5'h10;
   localparam logic [4:0] CNT_FRAME_DONE = 5'h18;
   localparam logic RW_WRITE = 1'h0;
   localparam logic RW_READ = 1'h1;
   // register offsets
   localparam logic [14:0] ADDR_STAGE_BIAS = 15'h0100;
   localparam logic [14:0] ADDR_MUTE_MASK = 15'h0101;
   localparam logic [14:0] ADDR_ON_MASK = 15'h0102;
   localparam logic [14:0] ADDR_UNLOCK_MUTE = 15'h0103;
   localparam logic [14:0] ADDR_INT_LOW = 15'h0200;
   localparam logic [14:0] ADDR_INT_HIGH = 15'h0201;
   localparam logic [14:0] ADDR_REF_DIV = 15'h020C;
   localparam logic [14:0] ADDR_REF_CFG = 15'h020E;
   localparam logic [14:0] ADDR_LOCK_CFG = 15'h0214;
   localparam logic [14:0] ADDR_LOCK_STATUS = 15'h024D;
   localparam logic [14:0] ADDR_PIN_SET = 15'h0307;
   // reset values
   localparam logic [7:0] RST_STAGE_BIAS = 8'hDF;
   localparam logic [7:0] RST_MUTE_MASK = 8'hBF;
   localparam logic [7:0] RST_ON_MASK = 8'hFF;
   localparam logic [7:0] RST_UNLOCK_MUTE = 8'h01;
   localparam logic [7:0] RST_INT_LOW = 8'h90;
   localparam logic [7:0] RST_INT_HIGH = 8'h01;
   localparam logic [7:0] RST_REF_DIV = 8'h01;
   localparam logic [7:0] RST_REF_CFG = 8'h04;
   localparam logic [7:0] RST_LOCK_CFG = 8'h48;
   localparam logic [7:0] RST_PIN_SET = 8'h00;
   // field positions
   localparam int UNLOCK_MUTE_BIT = 0;
   localparam int LOCK_STATUS_BIT = 0;
   localparam int LO_AMP_STAGE = 1;
   localparam int REF_HALVE_BIT = 0;
   localparam int REF_DOUBLER_BIT = 3;
   localparam int REF_DIV_MSB = 4;
   localparam int LOCK_WIN_LSB = 6;
   localparam int LOCK_CNT_LSB = 3;
   localparam int PIN_COUNT = 3;
   // lock counter: threshold is (lock_cycle_count + 1) units of cycles
   localparam int LOCK_UNIT_SHIFT = 4;
   localparam int LOCK_CNT_W = 8;
   localparam int SYNC_INPUTS = 6;

   typedef enum logic [1:0] {
      SSM_IDLE = 2'b00,
      SSM_HEAD = 2'b01,
      SSM_BODY = 2'b11,
      SSM_DONE = 2'b10
   } ssm_state_e;

   typedef struct packed {
      logic rw;
      logic [14:0] addr;
      logic [7:0] data;
   } ssm_frame_s;

   typedef struct packed {
      logic [15:0] feedback_integer;
      logic [4:0] ref_divide;
      logic reference_halving_select;
      logic doubler_enable;
   } ssm_synth_s;
endpackage

// ---- logic/ssm_stage_mask_control.sv ----
// serial register port, stage mask logic, double buffered synthesizer settings and lock detect
module ssm_stage_mask_control
   import ssm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // serial port pins
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic chip_select_n,
   output logic serial_out,
   output logic serial_out_oe,
   // stage control pins
   input wire logic mute_pin,
   input wire logic receiver_on_pin,
   output logic [7:0] stage_on,
   // synthesizer
   input wire logic phase_in_window,
   output logic [1:0] lock_window_setting,
   output logic multiplexed_status_output,
   output ssm_synth_s synth_active,
   output logic calibration_start,
   // digital pins
   output logic [PIN_COUNT-1:0] general_digital_pins
);
   logic rst_meta_q, rst_sync_n_q;
   logic [SYNC_INPUTS-1:0] meta_q, sync_q;
   logic sclk_prev_q;
   logic sclk_s, sdi_s, cs_n_s, mute_s, on_s, win_s;
   logic sclk_rise, sclk_fall;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   // every pin input passes two flops; the first is read only by the second
   logic [SYNC_INPUTS-1:0] raw_in;
   assign raw_in = {phase_in_window, receiver_on_pin, mute_pin, chip_select_n, serial_in, serial_clk};
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_INPUTS; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk or negedge rst_sync_n_q)
         begin
            if (!rst_sync_n_q)
            begin
               meta_q[gi] <= (gi == 2);
               sync_q[gi] <= (gi == 2);
            end
            else
            begin
               meta_q[gi] <= raw_in[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate
   assign {win_s, on_s, mute_s, cs_n_s, sdi_s, sclk_s} = sync_q;
   assign sclk_rise = sclk_s && !sclk_prev_q;
   assign sclk_fall = !sclk_s && sclk_prev_q;

   // serial port and register state
   ssm_state_e state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   ssm_frame_s frm_q, frm_d;
   logic [7:0] rdata_q, rdata_d;
   logic sdo_q, sdo_d, oe_q, oe_d;
   logic [7:0] bias_q, bias_d, mmask_q, mmask_d, omask_q, omask_d, umute_q, umute_d;
   logic [7:0] intl_q, intl_d, inth_q, inth_d, rdiv_q, rdiv_d, rcfg_q, rcfg_d;
   logic [7:0] ldcfg_q, ldcfg_d, pins_q, pins_d;
   ssm_synth_s act_q, act_d;
   logic cal_q, cal_d;
   logic lock_q;
   logic [4:0] cnt_inc;
   logic wr_en;
   logic [14:0] wr_addr;
   logic [7:0] wr_data;

   function automatic logic [7:0] reg_read(input logic [14:0] a, input logic [7:0] b, input logic [7:0] m,
         input logic [7:0] o, input logic [7:0] u, input logic [7:0] il, input logic [7:0] ih,
         input logic [7:0] rd, input logic [7:0] rc, input logic [7:0] lc, input logic [7:0] p,
         input logic lk);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_STAGE_BIAS: v = b;
         ADDR_MUTE_MASK: v = m;
         ADDR_ON_MASK: v = o;
         ADDR_UNLOCK_MUTE: v = u;
         ADDR_INT_LOW: v = il;
         ADDR_INT_HIGH: v = ih;
         ADDR_REF_DIV: v = rd;
         ADDR_REF_CFG: v = rc;
         ADDR_LOCK_CFG: v = lc;
         ADDR_LOCK_STATUS: v[LOCK_STATUS_BIT] = lk;
         ADDR_PIN_SET: v = p;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      frm_d = frm_q;
      rdata_d = rdata_q;
      sdo_d = sdo_q;
      oe_d = oe_q;
      wr_en = 1'b0;
      cnt_inc = cnt_q + 5'h01;
      if (cs_n_s)
      begin
         // a frame cut short never reaches the commit below
         state_d = SSM_IDLE;
         cnt_d = 5'h00;
         oe_d = 1'b0;
         sdo_d = 1'b0;
      end
      else
      begin
         case (state_q)
            SSM_IDLE:
               state_d = SSM_HEAD;
            SSM_HEAD, SSM_BODY:
            begin
               if (sclk_rise)
               begin
                  cnt_d = cnt_inc;
                  // fields arrive least significant bit first
                  if (cnt_q == 5'h00)
                     frm_d.rw = sdi_s;
                  else if (cnt_q < CNT_INSTR_DONE)
                     frm_d.addr = {sdi_s, frm_q.addr[14:1]};
                  else
                     frm_d.data = {sdi_s, frm_q.data[7:1]};
                  if (cnt_inc == CNT_INSTR_DONE)
                  begin
                     state_d = SSM_BODY;
                     if (frm_q.rw == RW_READ)
                     begin
                        rdata_d = reg_read(frm_d.addr, bias_q, mmask_q, omask_q, umute_q, intl_q, inth_q,
                           rdiv_q, rcfg_q, ldcfg_q, pins_q, lock_q);
                        oe_d = 1'b1;
                        sdo_d = rdata_d[0];
                     end
                  end
                  if (cnt_inc == CNT_FRAME_DONE)
                  begin
                     state_d = SSM_DONE;
                     wr_en = (frm_q.rw == RW_WRITE);
                  end
               end
               else if (sclk_fall && oe_q && cnt_q > CNT_INSTR_DONE)
                  sdo_d = rdata_q[3'(cnt_q - CNT_INSTR_DONE)];
            end
            SSM_DONE:
               state_d = SSM_DONE;
            default:
               state_d = SSM_IDLE;
         endcase
      end
   end

   assign wr_addr = frm_q.addr;
   assign wr_data = frm_d.data;

   always_comb
   begin
      bias_d = bias_q;
      mmask_d = mmask_q;
      omask_d = omask_q;
      umute_d = umute_q;
      intl_d = intl_q;
      inth_d = inth_q;
      rdiv_d = rdiv_q;
      rcfg_d = rcfg_q;
      ldcfg_d = ldcfg_q;
      pins_d = pins_q;
      act_d = act_q;
      cal_d = 1'b0;
      if (wr_en)
      begin
         case (wr_addr)
            ADDR_STAGE_BIAS: bias_d = wr_data;
            ADDR_MUTE_MASK: mmask_d = wr_data;
            ADDR_ON_MASK: omask_d = wr_data;
            ADDR_UNLOCK_MUTE: umute_d = wr_data;
            ADDR_INT_HIGH: inth_d = wr_data;
            ADDR_REF_DIV: rdiv_d = wr_data;
            ADDR_REF_CFG: rcfg_d = wr_data;
            ADDR_LOCK_CFG: ldcfg_d = wr_data;
            ADDR_PIN_SET: pins_d = wr_data;
            ADDR_INT_LOW:
            begin
               // shadows reach the synthesizer only here, so a half-written plan never runs
               intl_d = wr_data;
               act_d.feedback_integer = {inth_q, wr_data};
               act_d.ref_divide = rdiv_q[REF_DIV_MSB:0];
               act_d.reference_halving_select = rcfg_q[REF_HALVE_BIT];
               act_d.doubler_enable = rcfg_q[REF_DOUBLER_BIT];
               cal_d = 1'b1;
            end
            default: ;
         endcase
      end
   end

   // lock detect: consecutive cycles inside the window; calibration restarts the count
   logic [LOCK_CNT_W-1:0] lcnt_q, lcnt_d, lthr;
   logic lock_d;
   // widen before the add and shift so the top threshold value keeps its carry
   assign lthr = (LOCK_CNT_W'(ldcfg_q[LOCK_CNT_LSB +: 3]) + LOCK_CNT_W'(1)) << LOCK_UNIT_SHIFT;
   always_comb
   begin
      lcnt_d = lcnt_q;
      lock_d = lock_q;
      if (cal_q || !win_s)
      begin
         lcnt_d = '0;
         lock_d = 1'b0;
      end
      else if (lcnt_q >= lthr)
         lock_d = 1'b1;
      else
         lcnt_d = lcnt_q + LOCK_CNT_W'(1);
   end

   // stage status, one identical slice per stage; bit 1 is the LO amplifier
   logic mute_any;
   logic [7:0] stage_d;
   assign mute_any = mute_s || (umute_q[UNLOCK_MUTE_BIT] && !lock_q);
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_stage
         always_comb
         begin
            if (mute_any && mmask_q[gi])
               stage_d[gi] = 1'b0;
            else if (omask_q[gi])
               stage_d[gi] = on_s && bias_q[gi];
            else
               stage_d[gi] = bias_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_sync_n_q)
   begin
      if (!rst_sync_n_q)
      begin
         sclk_prev_q <= 1'b0;
         state_q <= SSM_IDLE;
         cnt_q <= 5'h00;
         frm_q <= '0;
         rdata_q <= 8'h00;
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
         bias_q <= RST_STAGE_BIAS;
         mmask_q <= RST_MUTE_MASK;
         omask_q <= RST_ON_MASK;
         umute_q <= RST_UNLOCK_MUTE;
         intl_q <= RST_INT_LOW;
         inth_q <= RST_INT_HIGH;
         rdiv_q <= RST_REF_DIV;
         rcfg_q <= RST_REF_CFG;
         ldcfg_q <= RST_LOCK_CFG;
         pins_q <= RST_PIN_SET;
         act_q <= {RST_INT_HIGH, RST_INT_LOW, RST_REF_DIV[REF_DIV_MSB:0], RST_REF_CFG[REF_HALVE_BIT],
            RST_REF_CFG[REF_DOUBLER_BIT]};
         cal_q <= 1'b0;
         lcnt_q <= '0;
         lock_q <= 1'b0;
         stage_on <= 8'h00;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
         state_q <= state_d;
         cnt_q <= cnt_d;
         frm_q <= frm_d;
         rdata_q <= rdata_d;
         sdo_q <= sdo_d;
         oe_q <= oe_d;
         bias_q <= bias_d;
         mmask_q <= mmask_d;
         omask_q <= omask_d;
         umute_q <= umute_d;
         intl_q <= intl_d;
         inth_q <= inth_d;
         rdiv_q <= rdiv_d;
         rcfg_q <= rcfg_d;
         ldcfg_q <= ldcfg_d;
         pins_q <= pins_d;
         act_q <= act_d;
         cal_q <= cal_d;
         lcnt_q <= lcnt_d;
         lock_q <= lock_d;
         stage_on <= stage_d;
      end
   end

   assign serial_out = sdo_q;
   assign serial_out_oe = oe_q;
   assign synth_active = act_q;
   assign calibration_start = cal_q;
   assign multiplexed_status_output = lock_q;
   assign lock_window_setting = ldcfg_q[LOCK_WIN_LSB +: 2];
   assign general_digital_pins = pins_q[PIN_COUNT-1:0];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_sync_n_q);

   a_oe_off_select: assert property (cs_n_s |=> !serial_out_oe)
      else $error("data driver on while select high");
   a_oe_after_instr: assert property (sclk_rise && !cs_n_s && cnt_q == 5'h0F && frm_q.rw && state_q == SSM_HEAD
      |=> serial_out_oe && serial_out == rdata_q[0])
      else $error("read driver not enabled after instruction");
   a_oe_holds: assert property (serial_out_oe && !cs_n_s |=> serial_out_oe)
      else $error("read driver dropped during frame");
   a_no_write_read: assert property (frm_q.rw == RW_READ |-> !wr_en)
      else $error("read frame caused a write");
   a_shadow_held: assert property (wr_en && wr_addr == ADDR_INT_HIGH |=> $stable(synth_active))
      else $error("high byte applied without low byte");
   a_commit_cal: assert property (wr_en && wr_addr == ADDR_INT_LOW
      |=> calibration_start && synth_active.feedback_integer == {inth_q, intl_q} ##1 !calibration_start)
      else $error("low byte write did not commit");
   a_mute_forces: assert property (mute_any && mmask_q[LO_AMP_STAGE] |=> !stage_on[LO_AMP_STAGE])
      else $error("masked mute did not block stage");
   a_on_pin_gate: assert property (!mute_any && omask_q[LO_AMP_STAGE] && !on_s
      |=> !stage_on[LO_AMP_STAGE])
      else $error("on pin low did not block stage");
   a_lock_window: assert property (!win_s |=> !multiplexed_status_output)
      else $error("lock held outside window");
   a_short_frame: assert property (cs_n_s && state_q != SSM_DONE |-> !wr_en)
      else $error("partial frame wrote a register");
endmodule

// ---- test/ssm_host_model.sv ----
// serial host model that frames register transfers on the serial port
module ssm_host_model
   import ssm_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // serial port pins
   output logic serial_clk,
   output logic serial_in,
   output logic chip_select_n,
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      serial_clk = 1'b0;
      serial_in = 1'b0;
      chip_select_n = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // fewer than 24 bits cuts the frame short; clock stands low outside frames
   task automatic xfer(input ssm_frame_s f, input int n_bits, output logic [7:0] q, output logic oe_seen);
      logic [23:0] bits;
      bits = {f.data, f.addr, f.rw};
      q = 8'h00;
      oe_seen = 1'b1;
      tick(1);
      chip_select_n = 1'b0;
      for (int i = 0; i < n_bits; i++)
      begin
         serial_in = bits[i];
         tick(4);
         serial_clk = 1'b1;
         if (i >= 16)
         begin
            q[i-16] = serial_out;
            oe_seen &= serial_out_oe;
         end
         tick(4);
         serial_clk = 1'b0;
      end
      tick(4);
      chip_select_n = 1'b1;
      // no pull on the data line: flip it so a stale level is never mistaken for data
      serial_in = ~serial_in;
      tick(6);
   endtask
endmodule

// ---- test/tb_ssm_stage_mask_control.sv ----
// self-checking bench for the stage mask control block with a reference model
module tb_ssm_stage_mask_control
   import ssm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic serial_clk, serial_in, chip_select_n, serial_out, serial_out_oe;
   logic mute_pin = 1'b0;
   logic receiver_on_pin = 1'b0;
   logic phase_in_window = 1'b0;
   logic [7:0] stage_on;
   logic [1:0] lock_window_setting;
   logic multiplexed_status_output, calibration_start;
   ssm_synth_s synth_active;
   logic [PIN_COUNT-1:0] general_digital_pins;
   int n_fail = 0;
   int total_checks = 0;
   int n_cal = 0;
   int exp_cal = 0;
   int m_lock = 0;
   int mdl[int];
   logic [14:0] amap[$];
   ssm_synth_s act_m;
   logic [7:0] cut_q;
   logic cut_oe;

   always #25 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
      if (calibration_start === 1'b1)
         n_cal++;

   ssm_stage_mask_control dut (.sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(serial_clk),
      .serial_in(serial_in), .chip_select_n(chip_select_n), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .mute_pin(mute_pin), .receiver_on_pin(receiver_on_pin),
      .stage_on(stage_on), .phase_in_window(phase_in_window), .lock_window_setting(lock_window_setting),
      .multiplexed_status_output(multiplexed_status_output), .synth_active(synth_active),
      .calibration_start(calibration_start), .general_digital_pins(general_digital_pins));

   ssm_host_model host (.sys_clk(sys_clk), .serial_clk(serial_clk), .serial_in(serial_in),
      .chip_select_n(chip_select_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // active synthesizer settings as the model expects them after a commit
   function automatic ssm_synth_s syn_of();
      return {8'(mdl['h201]), 8'(mdl['h200]), 5'(mdl['h20C]), 1'(mdl['h20E]), 1'(mdl['h20E] >> 3)};
   endfunction

   function automatic logic [7:0] exp_stage();
      logic [7:0] b, mm, om;
      logic mute;
      b = 8'(mdl['h100]);
      mm = 8'(mdl['h101]);
      om = 8'(mdl['h102]);
      mute = mute_pin | ((mdl['h103] & 1) != 0 && m_lock == 0);
      return ~({8{mute}} & mm) & ((~om & b) | (om & b & {8{receiver_on_pin}}));
   endfunction

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic oe;
      host.xfer('{RW_WRITE, a, d}, FRAME_BITS, q, oe);
      if (mdl.exists(a) && a != ADDR_LOCK_STATUS)
         mdl[a] = d;
      if (a == ADDR_INT_LOW)
      begin
         exp_cal++;
         m_lock = 0;
         act_m = syn_of();
      end
   endtask

   task automatic rd(input logic [14:0] a);
      logic [7:0] q;
      logic oe;
      int e;
      e = !mdl.exists(a) ? 0 : (a == ADDR_LOCK_STATUS ? m_lock : mdl[a]);
      host.xfer('{RW_READ, a, 8'h00}, FRAME_BITS, q, oe);
      check(q, e[7:0], "read data");
      check(oe, 1'b1, "data pin driven");
      check(serial_out_oe, 1'b0, "data pin released");
   endtask

   task automatic stage_rand(input int n);
      for (int k = 0; k < n; k++)
      begin
         wr(15'(ADDR_STAGE_BIAS + k % 4), 8'($urandom));
         mute_pin = 1'($urandom);
         receiver_on_pin = 1'($urandom);
         tick(6);
         check(stage_on, exp_stage(), "stage on");
      end
   endtask

   initial
   begin
      #3000000;
      n_fail++;
      wrap_up();
   end

   initial
   begin
      void'($urandom(60333));
      amap = '{ADDR_STAGE_BIAS, ADDR_MUTE_MASK, ADDR_ON_MASK, ADDR_UNLOCK_MUTE, ADDR_INT_LOW, ADDR_INT_HIGH,
         ADDR_REF_DIV, ADDR_REF_CFG, ADDR_LOCK_CFG, ADDR_LOCK_STATUS, ADDR_PIN_SET};
      mdl = '{'h100: RST_STAGE_BIAS, 'h101: RST_MUTE_MASK, 'h102: RST_ON_MASK, 'h103: RST_UNLOCK_MUTE,
         'h200: RST_INT_LOW, 'h201: RST_INT_HIGH, 'h20C: RST_REF_DIV, 'h20E: RST_REF_CFG,
         'h214: RST_LOCK_CFG, 'h24D: 0, 'h307: RST_PIN_SET};
      act_m = syn_of();
      tick(3);
      reset_n = 1'b1;
      tick(6);
      check(serial_out_oe, 1'b0, "idle data pin");
      check(synth_active, syn_of(), "reset synth");
      check(lock_window_setting, RST_LOCK_CFG[7:6], "window setting");
      foreach (amap[i])
         rd(amap[i]);
      rd(15'h0005);
      // recommended start-up writes; the serial configuration and init-only registers are ignored here
      wr(15'h0000, 8'h99);
      wr(15'h0000, 8'h18);
      wr(ADDR_UNLOCK_MUTE, 8'h00);
      wr(15'h0300, 8'h1F);
      stage_rand(24);
      // buffered registers in the recommended order, low byte last
      for (int k = 0; k < 2; k++)
      begin
         wr(ADDR_REF_DIV, 8'($urandom % 32));
         wr(ADDR_REF_CFG, 8'($urandom));
         wr(ADDR_INT_HIGH, 8'($urandom));
         check(synth_active, act_m, "held");
         check(n_cal, exp_cal, "no calibration on shadow write");
         wr(ADDR_INT_LOW, 8'($urandom));
         check(synth_active, syn_of(), "commit");
         check(n_cal, exp_cal, "calibration pulses");
      end
      wr(ADDR_PIN_SET, 8'($urandom));
      check(general_digital_pins, mdl['h307] & 7, "digital pins");
      wr(ADDR_LOCK_CFG, 8'h8D);
      check(lock_window_setting, 2'b10, "window setting");
      host.xfer('{RW_WRITE, ADDR_STAGE_BIAS, 8'h5A}, 20, cut_q, cut_oe);
      rd(ADDR_STAGE_BIAS);
      wr(ADDR_LOCK_STATUS, 8'hFF);
      wr(15'h0005, 8'h77);
      rd(15'h0005);
      phase_in_window = 1'b1;
      tick(20);
      check(multiplexed_status_output, 1'b0, "early lock");
      tick(40);
      m_lock = 1;
      check(multiplexed_status_output, 1'b1, "lock");
      rd(ADDR_LOCK_STATUS);
      stage_rand(8);
      wr(ADDR_INT_LOW, 8'h33);
      check(multiplexed_status_output, 1'b0, "lock after commit");
      tick(50);
      m_lock = 1;
      phase_in_window = 1'b0;
      tick(8);
      m_lock = 0;
      check(multiplexed_status_output, 1'b0, "lock lost");
      stage_rand(4);
      foreach (amap[i])
         rd(amap[i]);
      wrap_up();
   end
endmodule
